// ---- ccrp_pkg.sv ----
// constants shared by the cluster clear/preset block and its register file
// assumes a 32-bit apb slave in front of one logic_array_block register cluster
package ccrp_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CCRP_CTRL_OFS = 8'h00;
  localparam logic [7:0] CCRP_CLRSEL_OFS = 8'h04;
  localparam logic [7:0] CCRP_PRESEL_OFS = 8'h08;
  localparam logic [7:0] CCRP_STATUS_OFS = 8'h0c;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CCRP_CTRL_CLR0_BIT = 0;
  localparam int CCRP_CTRL_CLR1_BIT = 1;
  localparam int CCRP_CTRL_PRE_BIT = 2;
  localparam int CCRP_STAT_LINE_POS = 16;
  localparam logic [2:0] CCRP_CTRL_RST = 3'h0;
  localparam logic [31:0] CCRP_CLRSEL_RST = 32'h0000_0000;
  localparam logic [15:0] CCRP_PRESEL_RST = 16'h0000;

  // per-register clear select, two bits each
  localparam logic [1:0] CCRP_SEL_NONE = 2'h0;
  localparam logic [1:0] CCRP_SEL_CLR0 = 2'h1;
  localparam logic [1:0] CCRP_SEL_CLR1 = 2'h2;

  typedef enum logic [2:0] {
    CCRP_REG_CTRL,
    CCRP_REG_CLRSEL,
    CCRP_REG_PRESEL,
    CCRP_REG_STATUS,
    CCRP_REG_NONE
  } ccrp_reg_type;

endpackage

// ---- ccrp_cell.sv ----
// one adaptive_logic_cell register with direct asynchronous clear and load-one
// assumes aclr/aload come from the cluster-wide lines, decoded in the parent
`timescale 1ns/1ns
`default_nettype none
module ccrp_cell
  import ccrp_pkg::*;
(
  input wire logic clk,
  input wire logic ce,
  input wire logic srst,
  input wire logic d,
  input wire logic aclr,
  input wire logic aload,
  output var logic q_ff
);

  logic nxt_q;

  // ---------------------------------------------------------------
  // next value: zero on srst, data when ce is high, held otherwise
  // ---------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    if (srst) begin
      nxt_q = 1'b0;
    end else if (ce) begin
      nxt_q = d;
    end
  end

  // clear tested first so it wins; preset is a true load of one, not an inverted clear
  always_ff @(posedge clk or posedge aclr or posedge aload) begin
    if (aclr) begin
      q_ff <= 1'b0;
    end else if (aload) begin
      q_ff <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule
`default_nettype wire

// ---- ccrp_cluster.sv ----
// register cluster with shared clear/preset lines, global clear and apb setup
// assumes pclk is clk, apb master per amba apb; inputs synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module ccrp_cluster
  import ccrp_pkg::*;
#(
  parameter int CELL_COUNT = 16,
  parameter bit GLOBAL_CLEAR_EN = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] cluster_clear,
  input wire logic cluster_preset,
  input wire logic global_register_clear_n,
  input wire logic [CELL_COUNT-1:0] cell_d,
  output logic [CELL_COUNT-1:0] cell_q
);

  logic [2:0] ctrl_ff, nxt_ctrl;
  logic [31:0] clrsel_ff, nxt_clrsel;
  logic [15:0] presel_ff, nxt_presel;
  logic [31:0] nxt_prdata;
  logic [1:0] clear_line;
  logic preset_line;
  logic glb_active;
  logic [CELL_COUNT-1:0] cell_clr, cell_pre;
  ccrp_reg_type hit;

  function automatic ccrp_reg_type ccrp_decode(input logic [7:0] addr);
    if (addr == CCRP_CTRL_OFS) begin
      return CCRP_REG_CTRL;
    end else if (addr == CCRP_CLRSEL_OFS) begin
      return CCRP_REG_CLRSEL;
    end else if (addr == CCRP_PRESEL_OFS) begin
      return CCRP_REG_PRESEL;
    end else if (addr == CCRP_STATUS_OFS) begin
      return CCRP_REG_STATUS;
    end else begin
      return CCRP_REG_NONE;
    end
  endfunction

  // ---------------------------------------------------------------
  // cluster-wide control lines
  // ---------------------------------------------------------------
  // software bits are or-ed with the pins so either source can drive a line
  assign clear_line[0] = cluster_clear[0] | ctrl_ff[CCRP_CTRL_CLR0_BIT];
  assign clear_line[1] = cluster_clear[1] | ctrl_ff[CCRP_CTRL_CLR1_BIT];
  assign preset_line = cluster_preset | ctrl_ff[CCRP_CTRL_PRE_BIT];
  assign glb_active = GLOBAL_CLEAR_EN & ~global_register_clear_n;

  genvar gi;
  generate
    for (gi = 0; gi < CELL_COUNT; gi++) begin : g_cell
      logic [1:0] sel;
      assign sel = clrsel_ff[2*gi +: 2];
      // global clear joins the async clear, so it beats ce, clock and preset
      assign cell_clr[gi] = glb_active |
                            (sel == CCRP_SEL_CLR0 & clear_line[0]) |
                            (sel == CCRP_SEL_CLR1 & clear_line[1]);
      assign cell_pre[gi] = presel_ff[gi] & preset_line;
      ccrp_cell u_cell (
        .clk(clk),
        .ce(ce),
        .srst(srst),
        .d(cell_d[gi]),
        .aclr(cell_clr[gi]),
        .aload(cell_pre[gi]),
        .q_ff(cell_q[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------------------------
  assign hit = ccrp_decode(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & (hit == CCRP_REG_NONE);

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_clrsel = clrsel_ff;
    nxt_presel = presel_ff;
    nxt_prdata = prdata;
    // ce low leaves the bus branches idle, so unless srst is high the defaults above hold every register
    if (srst) begin
      nxt_ctrl = CCRP_CTRL_RST;
      nxt_clrsel = CCRP_CLRSEL_RST;
      nxt_presel = CCRP_PRESEL_RST;
      nxt_prdata = 32'h0000_0000;
    end else if (ce & psel & ~penable & ~pwrite) begin
      // read data is staged in setup so it comes from a flop in the access phase
      nxt_prdata = 32'h0000_0000;
      if (ccrp_decode(paddr) == CCRP_REG_CTRL) begin
        nxt_prdata[2:0] = ctrl_ff;
      end else if (ccrp_decode(paddr) == CCRP_REG_CLRSEL) begin
        nxt_prdata = clrsel_ff;
      end else if (ccrp_decode(paddr) == CCRP_REG_PRESEL) begin
        nxt_prdata[15:0] = presel_ff;
      end else if (ccrp_decode(paddr) == CCRP_REG_STATUS) begin
        nxt_prdata[CELL_COUNT-1:0] = cell_q;
        nxt_prdata[CCRP_STAT_LINE_POS +: 4] = {glb_active, preset_line, clear_line};
      end
    end else if (ce & psel & penable & pwrite) begin
      if (hit == CCRP_REG_CTRL) begin
        nxt_ctrl = pwdata[2:0];
      end else if (hit == CCRP_REG_CLRSEL) begin
        nxt_clrsel = pwdata;
      end else if (hit == CCRP_REG_PRESEL) begin
        nxt_presel = pwdata[15:0];
      end
    end
  end

  // clock enable gates the bus terms above but not srst, so the setup registers freeze with it unless srst is high
  always_ff @(posedge clk) begin
    ctrl_ff <= nxt_ctrl;
    clrsel_ff <= nxt_clrsel;
    presel_ff <= nxt_presel;
    prdata <= nxt_prdata;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [CELL_COUNT-1:0] quiet_now;
  assign quiet_now = ~(cell_clr | cell_pre);
  // forcing is asynchronous, so the forcing checks other than a_global_beats_all also want the control high at the previous edge

  a_clear_forces_zero: assert property (@(posedge clk) disable iff (srst)
    ((cell_q & cell_clr & $past(cell_clr)) == '0))
    else $error("cleared register not at zero");

  a_preset_forces_one: assert property (@(posedge clk) disable iff (srst)
    ((~cell_q & cell_pre & $past(cell_pre) & ~cell_clr & ~$past(cell_clr)) == '0))
    else $error("preset register not at one");

  a_clear_beats_preset: assert property (@(posedge clk) disable iff (srst)
    ((cell_q & cell_clr & cell_pre & $past(cell_clr)) == '0))
    else $error("preset won over clear");

  a_global_clears_all: assert property (@(posedge clk) disable iff (srst)
    glb_active ##1 glb_active |-> cell_q == '0)
    else $error("global clear left a register set");

  a_global_beats_all: assert property (@(posedge clk) disable iff (srst)
    glb_active |-> (cell_clr == '1) && (cell_q == '0))
    else $error("global clear did not override every register");

  a_global_option_off: assert property (@(posedge clk) disable iff (srst)
    (!GLOBAL_CLEAR_EN && clear_line == 2'h0) |-> cell_clr == '0)
    else $error("global clear acted while disabled");

  a_capture_data: assert property (@(posedge clk) disable iff (srst)
    $past(ce) && !$past(srst) |->
      (((cell_q ^ $past(cell_d)) & quiet_now & $past(quiet_now)) == '0))
    else $error("register missed its data");

  a_hold_after_force: assert property (@(posedge clk) disable iff (srst)
    !$past(ce) && !$past(srst) |->
      (((cell_q ^ $past(cell_q)) & quiet_now & $past(quiet_now)) == '0))
    else $error("register changed without a clock load");

  a_shared_lines: assert property (@(posedge clk) disable iff (srst)
    (!glb_active && clear_line == 2'h0) |-> (cell_clr == '0) && (preset_line || (cell_pre == '0)))
    else $error("register forced without a cluster line");

  a_preset_select: assert property (@(posedge clk) disable iff (srst)
    ((cell_pre & ~presel_ff[CELL_COUNT-1:0]) == '0))
    else $error("preset reached an unselected register");

  a_unmapped_err: assert property (@(posedge clk) disable iff (srst)
    psel && penable && hit == CCRP_REG_NONE |-> pslverr && pready)
    else $error("unmapped access not flagged");

  a_ctrl_write: assert property (@(posedge clk) disable iff (srst)
    ce && psel && penable && pwrite && hit == CCRP_REG_CTRL |=> ctrl_ff == $past(pwdata[2:0]))
    else $error("control write did not land");

  a_status_lines: assert property (@(posedge clk) disable iff (srst)
    ce && psel && !penable && !pwrite && hit == CCRP_REG_STATUS |=>
      prdata[CCRP_STAT_LINE_POS +: 4] == $past({glb_active, preset_line, clear_line}))
    else $error("status read misreports the cluster lines");

  a_ce_freeze: assert property (@(posedge clk) disable iff (srst)
    !ce |=> $stable(ctrl_ff) && $stable(clrsel_ff) && $stable(presel_ff) && $stable(prdata))
    else $error("setup state moved while clock enable low");

  // ---------------------------------------------------------------
  // cover points
  // ---------------------------------------------------------------
  c_clear_and_preset: cover property (@(posedge clk) disable iff (srst) |(cell_clr & cell_pre));
  c_preset_only: cover property (@(posedge clk) disable iff (srst) |(cell_pre & ~cell_clr));
  c_global_clear: cover property (@(posedge clk) disable iff (srst) glb_active);
  c_apb_write: cover property (@(posedge clk) disable iff (srst) psel && penable && pwrite && hit == CCRP_REG_CLRSEL);
  c_forced_while_frozen: cover property (@(posedge clk) disable iff (srst) !ce && |(cell_clr | cell_pre));

endmodule
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the register cluster with shared clear/preset lines
// assumes ccrp_pkg and ccrp_cluster are compiled first; apb slave answers with no wait state
`timescale 1ns/1ns
`default_nettype none
module testbench
  import ccrp_pkg::*;
;
  // ---------------------------------------------------------------
  // stimulus and design
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] cluster_clear = 2'h0;
  logic cluster_preset = 1'b0;
  logic global_register_clear_n = 1'b1;
  logic [15:0] cell_d = 16'h0;
  logic [15:0] cell_q;
  logic [15:0] cell_q_off;
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 32'hf296;
  logic [31:0] rd;
  logic err;
  logic [15:0] v;

  always #25 clk = ~clk;

  ccrp_cluster #(.CELL_COUNT(16), .GLOBAL_CLEAR_EN(1'b1)) uut (.clk(clk), .srst(srst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cluster_clear(cluster_clear),
    .cluster_preset(cluster_preset), .global_register_clear_n(global_register_clear_n),
    .cell_d(cell_d), .cell_q(cell_q));
  // twin built without the global clear, fed the same traffic
  ccrp_cluster #(.CELL_COUNT(16), .GLOBAL_CLEAR_EN(1'b0)) uut_off (.clk(clk), .srst(srst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(), .pready(), .pslverr(), .cluster_clear(cluster_clear),
    .cluster_preset(cluster_preset), .global_register_clear_n(global_register_clear_n),
    .cell_d(cell_d), .cell_q(cell_q_off));

  // ---------------------------------------------------------------
  // tasks and expectations
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // waits on pready, so no latency is assumed; only the watchdog ends a hung wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // clear beats preset on each cell
  function automatic logic [15:0] force_q(input logic [15:0] q, input logic [31:0] sel,
      input logic [1:0] clr, input logic pre, input logic [15:0] pmask);
    logic [15:0] r;
    r = q;
    for (int i = 0; i < 16; i++) begin
      if (pre && pmask[i]) r[i] = 1'b1;
      if ((sel[2*i+:2] == CCRP_SEL_CLR0 && clr[0]) || (sel[2*i+:2] == CCRP_SEL_CLR1 && clr[1])) r[i] = 1'b0;
    end
    return r;
  endfunction

  task automatic print_verdict();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    #(50 * 4000);
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("q_reset", 32'h0, 32'(cell_q));
    apb(1'b0, CCRP_CLRSEL_OFS, 32'h0);
    chk("clrsel_reset", CCRP_CLRSEL_RST, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    repeat (8) begin
      @(posedge clk);
      v = 16'($random(seed));
      cell_d <= v;
      @(posedge clk);
      @(negedge clk);
      chk("capture", 32'(v), 32'(cell_q));
    end
    // even cells on line0, odd cells on line1 and on the preset line
    apb(1'b1, CCRP_CLRSEL_OFS, 32'h9999_9999);
    apb(1'b1, CCRP_PRESEL_OFS, 32'h0000_aaaa);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      ce <= 1'b0;
      cluster_clear <= k[1:0];
      cluster_preset <= k[2];
      @(negedge clk);
      chk("forced_q", 32'(force_q(v, 32'h9999_9999, k[1:0], k[2], 16'haaaa)), 32'(cell_q));
      @(posedge clk);
      cluster_clear <= 2'h0;
      cluster_preset <= 1'b0;
      @(negedge clk);
      chk("held_q", 32'(force_q(v, 32'h9999_9999, k[1:0], k[2], 16'haaaa)), 32'(cell_q));
      @(posedge clk);
      ce <= 1'b1;
      v = 16'($random(seed));
      cell_d <= v;
      @(posedge clk);
      @(negedge clk);
      chk("reload", 32'(v), 32'(cell_q));
    end
    apb(1'b1, CCRP_CTRL_OFS, 32'h1);
    @(negedge clk);
    chk("sw_clear", 32'h0, 32'(cell_q & 16'h5555));
    apb(1'b1, CCRP_CTRL_OFS, 32'h0);
    @(posedge clk);
    global_register_clear_n <= 1'b0;
    cluster_preset <= 1'b1;
    repeat (3) begin
      @(posedge clk);
      v = 16'($random(seed));
      cell_d <= v;
      @(posedge clk);
      @(negedge clk);
      chk("global_clear", 32'h0, 32'(cell_q));
      chk("global_off", 32'(force_q(v, 32'h9999_9999, 2'h0, 1'b1, 16'haaaa)), 32'(cell_q_off));
    end
    apb(1'b0, CCRP_STATUS_OFS, 32'h0);
    chk("status", 32'h0000_000c << CCRP_STAT_LINE_POS, rd);
    global_register_clear_n <= 1'b1;
    cluster_preset <= 1'b0;
    // software clear1 and preset together on the odd cells: clear wins
    apb(1'b1, CCRP_CTRL_OFS, 32'h6);
    @(negedge clk);
    chk("sw_clear_wins", 32'h0, 32'(cell_q & 16'haaaa));
    apb(1'b0, CCRP_CTRL_OFS, 32'h0);
    chk("ctrl_readback", 32'h6, rd);
    apb(1'b1, CCRP_CTRL_OFS, 32'h0);
    apb(1'b1, CCRP_CTRL_OFS, 32'h4);
    @(negedge clk);
    chk("sw_preset", 32'haaaa, 32'(cell_q & 16'haaaa));
    apb(1'b1, CCRP_CTRL_OFS, 32'h0);
    // reset in mid-run returns the setup registers and the cells to zero
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("q_rerst", 32'h0, 32'(cell_q));
    apb(1'b0, CCRP_PRESEL_OFS, 32'h0);
    chk("presel_reset", 32'(CCRP_PRESEL_RST), rd);
    apb(1'b0, CCRP_CLRSEL_OFS, 32'h0);
    chk("clrsel_rerst", CCRP_CLRSEL_RST, rd);
    print_verdict();
  end
endmodule
`default_nettype wire
